// >>> cot_offset_trim_regs.sv
// Operation
// RULE1: Each register holds a 12-bit unsigned core offset.
// RULE2: Host writes zero to reserved bits; reset zero.
// RULE3: No host access while offset calibration runs.
// RULE4: Foreground-only offset cal: access after done flag.
// RULE5: Background plus continuous offset cal: never access.
// RULE6: Spare cores offset-calibrated during foreground step.
// RULE7: Otherwise host may access without waiting.
// RULE8: 16-bit locations, core0 0x330, core1 0x332.
// RULE9: Core2 uses pair A 0x334 or B 0x336.
// RULE10: Core3 trim at 0x338 applies for pair C.
// RULE11: Reset to zero, then load fuse defaults.
// RULE12: Reads return 12-bit value, upper bits zero.
`timescale 1ns/1ns
module cot_offset_trim_regs #(
    parameter int unsigned NUM_REGS = cot_pkg::COT_NUM_REGS
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  nrst_i,
    input  cot_pkg::cot_reg_req_t      reg_req_i,
    input  cot_pkg::cot_cal_cfg_t      cal_cfg_i,
    input  cot_pkg::cot_trim_wr_t      cal_wr_i,
    input  wire logic                  input_pair_b_i,
    input  wire logic                  input_pair_c_i,
    input  wire logic                  fault_clr_i,
    input  wire logic                  fuse_ack_i,
    input  wire logic [11:0]           fuse_data_i,
    output logic [15:0]                rd_data_o,
    output logic                       rd_valid_o,
    output logic [11:0]                core0_offset_o,
    output logic [11:0]                core1_offset_o,
    output logic [11:0]                core2_offset_o,
    output logic [11:0]                core3_offset_o,
    output logic                       spare_offset_cal_o,
    output logic                       host_blocked_o,
    output logic                       access_fault_o,
    output logic                       fuse_rd_o,
    output logic [2:0]                 fuse_idx_o,
    output logic                       load_done_o
);
    import cot_pkg::*;

    if (NUM_REGS != COT_NUM_REGS) begin : g_bad_num_regs
        $error("cot_offset_trim_regs: the address map serves exactly five registers");
    end

    function automatic logic [3:0] cot_decode(input logic [11:0] addr);
        logic [3:0] r;
        r = 4'h0;
        unique case (addr)
            COT_CORE0_OFFSET_TRIM:         r = {1'b1, COT_IDX_CORE0};
            COT_CORE1_OFFSET_TRIM:         r = {1'b1, COT_IDX_CORE1};
            COT_CORE2_INPUT_A_OFFSET_TRIM: r = {1'b1, COT_IDX_CORE2A};
            COT_CORE2_INPUT_B_OFFSET_TRIM: r = {1'b1, COT_IDX_CORE2B};
            COT_CORE3_INPUT_C_OFFSET_TRIM: r = {1'b1, COT_IDX_CORE3C};
            default:                       r = 4'h0;
        endcase
        return r;
    endfunction : cot_decode

    logic [11:0]   trim_q [NUM_REGS];
    cot_trim_wr_t  load_w;
    logic          load_done_w;
    logic          fuse_rd_w;
    logic [2:0]    fuse_idx_w;

    cot_fuse_loader #(
        .NUM_REGS   (NUM_REGS)
    ) u_fuse_loader (
        .sys_clk_i  (sys_clk_i),
        .nrst_i     (nrst_i),
        .fuse_ack_i (fuse_ack_i),
        .fuse_data_i(fuse_data_i),
        .fuse_rd_o  (fuse_rd_w),
        .fuse_idx_o (fuse_idx_w),
        .load_o     (load_w),
        .done_o     (load_done_w)
    );

    // Host access windows follow the calibration configuration.
    wire fg_only_w   = cal_cfg_i.offset_cal_en
                       && !(cal_cfg_i.background_cal_en
                            && cal_cfg_i.continuous_bg_offset_cal_en);
    wire wait_fg_w   = fg_only_w && !cal_cfg_i.foreground_cal_done;          // see RULE4
    wire bg_cont_w   = cal_cfg_i.background_cal_en
                       && cal_cfg_i.continuous_bg_offset_cal_en;             // see RULE5
    wire blocked_w   = cal_cfg_i.cal_running || wait_fg_w || bg_cont_w
                       || !load_done_w;                                      // see RULE3
    wire spare_cal_w = cal_cfg_i.offset_cal_en && cal_cfg_i.background_cal_en
                       && !cal_cfg_i.continuous_bg_offset_cal_en
                       && cal_cfg_i.cal_running;                             // see RULE6

    wire [3:0] dec_w     = cot_decode(reg_req_i.addr);
    wire       hit_w     = dec_w[3];                                         // see RULE8
    wire [2:0] idx_w     = dec_w[2:0];
    wire       host_wr_w = reg_req_i.wr && hit_w && !blocked_w;              // see RULE7
    wire       host_rd_w = reg_req_i.rd && hit_w && !blocked_w;
    // A refused access is counted as a fault so software can spot a bad sequence.
    wire       fault_w   = (reg_req_i.wr || reg_req_i.rd) && hit_w && blocked_w;

    // Fuse load wins, then the calibration engine, then the host.
    wire           cal_ok_w = cal_wr_i.we && load_done_w;
    cot_trim_wr_t  wr_sel_w;
    assign wr_sel_w = load_w.we ? load_w
                    : cal_ok_w  ? cal_wr_i
                    : cot_trim_wr_t'{we: host_wr_w, idx: idx_w,
                        data: reg_req_i.wdata[COT_TRIM_MSB:COT_TRIM_LSB]};   // see RULE2

    generate
        for (genvar g = 0; g < NUM_REGS; g++) begin : g_trim
            always_ff @(posedge sys_clk_i) begin
                if (!nrst_i) begin
                    trim_q[g] <= COT_TRIM_RESET;                             // see RULE11
                end else if (wr_sel_w.we && wr_sel_w.idx == 3'(g)) begin
                    trim_q[g] <= wr_sel_w.data;                              // see RULE1
                end
            end
        end
    endgenerate

    wire [11:0] rd_trim_w  = trim_q[idx_w];
    wire [15:0] rd_word_w  = host_rd_w ? {COT_RSVD_VAL, rd_trim_w} : 16'h0000; // see RULE12
    wire [11:0] core2_w    = input_pair_b_i ? trim_q[COT_IDX_CORE2B]
                                            : trim_q[COT_IDX_CORE2A];       // see RULE9
    wire [11:0] core3_w    = input_pair_c_i ? trim_q[COT_IDX_CORE3C]
                                            : 12'h000;                       // see RULE10

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rd_data_o          <= 16'h0000;
            rd_valid_o         <= 1'b0;
            core0_offset_o     <= 12'h000;
            core1_offset_o     <= 12'h000;
            core2_offset_o     <= 12'h000;
            core3_offset_o     <= 12'h000;
            spare_offset_cal_o <= 1'b0;
            host_blocked_o     <= 1'b1;
            access_fault_o     <= 1'b0;
            fuse_rd_o          <= 1'b0;
            fuse_idx_o         <= 3'h0;
            load_done_o        <= 1'b0;
        end else begin
            rd_data_o          <= rd_word_w;
            rd_valid_o         <= reg_req_i.rd;
            core0_offset_o     <= trim_q[COT_IDX_CORE0];                     // see RULE8
            core1_offset_o     <= trim_q[COT_IDX_CORE1];
            core2_offset_o     <= core2_w;
            core3_offset_o     <= core3_w;
            spare_offset_cal_o <= spare_cal_w;
            host_blocked_o     <= blocked_w;
            // Set wins over clear so a fault in the clear cycle is kept.
            access_fault_o     <= fault_w || (access_fault_o && !fault_clr_i);
            fuse_rd_o          <= fuse_rd_w;
            fuse_idx_o         <= fuse_idx_w;
            load_done_o        <= load_done_w;
        end
    end

    chk_rd_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE12
        rd_valid_o |-> rd_data_o[15:12] == 4'h0)
        else $error("reserved read bits not zero");

    chk_host_wr_lands: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE1
        host_wr_w && !load_w.we && !cal_ok_w |=> trim_q[$past(idx_w)] == $past(reg_req_i.wdata[11:0]))
        else $error("accepted host write not stored");

    chk_bg_cont_block: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE5
        cal_cfg_i.background_cal_en && cal_cfg_i.continuous_bg_offset_cal_en
        |=> host_blocked_o)
        else $error("access open during continuous background cal");

    chk_foreground_cal_done_wait: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE4
        cal_cfg_i.offset_cal_en && !cal_cfg_i.background_cal_en && !cal_cfg_i.foreground_cal_done
        && reg_req_i.wr && hit_w && !load_w.we && !cal_ok_w
        |=> access_fault_o && trim_q[$past(idx_w)] == $past(rd_trim_w))
        else $error("write taken before foreground done");

    chk_cal_run_block: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE3
        cal_cfg_i.cal_running && reg_req_i.rd && hit_w |=> rd_valid_o && rd_data_o == 16'h0000)
        else $error("read served while calibration runs");

    chk_spare_cal_flag: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE6
        ##1 spare_offset_cal_o == $past(cal_cfg_i.offset_cal_en && cal_cfg_i.background_cal_en
        && !cal_cfg_i.continuous_bg_offset_cal_en && cal_cfg_i.cal_running))
        else $error("spare core offset cal flag wrong");

    chk_core2_pair_sel: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE9
        ##1 core2_offset_o == ($past(input_pair_b_i) ? $past(trim_q[COT_IDX_CORE2B])
                                                     : $past(trim_q[COT_IDX_CORE2A])))
        else $error("core2 offset not from selected pair");

    chk_core3_pair_c: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE10
        input_pair_c_i |=> core3_offset_o == $past(trim_q[COT_IDX_CORE3C]))
        else $error("core3 offset not applied for pair c");

    chk_core0_own_reg: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE8
        ##1 core0_offset_o == $past(trim_q[COT_IDX_CORE0]))
        else $error("core0 offset not from its own register");

    chk_core1_own_reg: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE8
        ##1 core1_offset_o == $past(trim_q[COT_IDX_CORE1]))
        else $error("core1 offset not from its own register");

    chk_unmapped_rd_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE8
        reg_req_i.rd && !hit_w |=> rd_valid_o && rd_data_o == 16'h0000)
        else $error("unmapped read returned data");

    chk_core3_idle_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE10
        !input_pair_c_i |=> core3_offset_o == 12'h000)
        else $error("core3 offset applied without pair c");

    chk_load_gates_host: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE11
        !load_done_w |=> host_blocked_o)
        else $error("host access open before fuse load");

    chk_refused_wr_kept: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE3
        cal_cfg_i.cal_running && reg_req_i.wr && hit_w && !load_w.we && !cal_ok_w
        |=> trim_q[$past(idx_w)] == $past(rd_trim_w))
        else $error("write taken while calibration runs");

    // A refused access in the clear cycle must survive the clear.
    chk_fault_set_wins: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE3
        fault_w |=> access_fault_o)
        else $error("refused access not flagged");

endmodule : cot_offset_trim_regs

// >>> cot_pkg.sv
package cot_pkg;

    localparam int unsigned        COT_NUM_REGS     = 5;
    localparam int unsigned        COT_TRIM_W       = 12;
    localparam int unsigned        COT_REG_W        = 16;
    localparam int unsigned        COT_ADDR_W       = 12;
    localparam int unsigned        COT_IDX_W        = 3;

    // Register offsets; each trim register is one 16-bit location.
    localparam logic [11:0]        COT_CORE0_OFFSET_TRIM         = 12'h330;
    localparam logic [11:0]        COT_CORE1_OFFSET_TRIM         = 12'h332;
    localparam logic [11:0]        COT_CORE2_INPUT_A_OFFSET_TRIM = 12'h334;
    localparam logic [11:0]        COT_CORE2_INPUT_B_OFFSET_TRIM = 12'h336;
    localparam logic [11:0]        COT_CORE3_INPUT_C_OFFSET_TRIM = 12'h338;

    // Register indices inside the bank.
    localparam logic [2:0]         COT_IDX_CORE0    = 3'h0;
    localparam logic [2:0]         COT_IDX_CORE1    = 3'h1;
    localparam logic [2:0]         COT_IDX_CORE2A   = 3'h2;
    localparam logic [2:0]         COT_IDX_CORE2B   = 3'h3;
    localparam logic [2:0]         COT_IDX_CORE3C   = 3'h4;

    localparam int unsigned        COT_TRIM_LSB     = 0;
    localparam int unsigned        COT_TRIM_MSB     = 11;
    localparam logic [3:0]         COT_RSVD_VAL     = 4'h0;
    localparam logic [11:0]        COT_TRIM_RESET   = 12'h000;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [15:0] wdata;
    } cot_reg_req_t;

    typedef struct packed {
        logic offset_cal_en;
        logic background_cal_en;
        logic continuous_bg_offset_cal_en;
        logic foreground_cal_done;
        logic cal_running;
    } cot_cal_cfg_t;

    typedef struct packed {
        logic        we;
        logic [2:0]  idx;
        logic [11:0] data;
    } cot_trim_wr_t;

endpackage : cot_pkg

// >>> cot_fuse_loader.sv
`timescale 1ns/1ns
module cot_fuse_loader #(
    parameter int unsigned NUM_REGS = cot_pkg::COT_NUM_REGS
) (
    input  wire logic                sys_clk_i,
    input  wire logic                nrst_i,
    input  wire logic                fuse_ack_i,
    input  wire logic [11:0]         fuse_data_i,
    output logic                     fuse_rd_o,
    output logic [2:0]               fuse_idx_o,
    output cot_pkg::cot_trim_wr_t    load_o,
    output logic                     done_o
);
    import cot_pkg::*;

    // The index counter is three bits wide, so more than eight words cannot be walked.
    if (NUM_REGS < 1 || NUM_REGS > 8) begin : g_bad_num_regs
        $error("cot_fuse_loader: NUM_REGS must be 1 to 8");
    end

    typedef enum logic [2:0] {
        COT_LD_REQ  = 3'b001,
        COT_LD_WAIT = 3'b010,
        COT_LD_DONE = 3'b100
    } cot_ld_state_t;

    cot_ld_state_t state_q;
    cot_ld_state_t state_d;
    logic [2:0]    idx_q;
    logic [2:0]    idx_d;
    wire           last_w = (idx_q == 3'(NUM_REGS - 1));

    // One fuse word is asked for at a time, so a slow fuse array needs no buffer.
    always_comb begin
        state_d = state_q;
        idx_d   = idx_q;
        unique case (state_q)
            COT_LD_REQ: begin
                state_d = COT_LD_WAIT;
            end
            COT_LD_WAIT: begin
                if (fuse_ack_i) begin
                    state_d = last_w ? COT_LD_DONE : COT_LD_REQ;
                    idx_d   = last_w ? idx_q : idx_q + 3'h1;
                end
            end
            COT_LD_DONE: begin
                state_d = COT_LD_DONE;
            end
            default: begin
                state_d = COT_LD_REQ;
                idx_d   = 3'h0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            state_q <= COT_LD_REQ;
            idx_q   <= 3'h0;
        end else begin
            state_q <= state_d;
            idx_q   <= idx_d;
        end
    end

    assign fuse_rd_o    = (state_q == COT_LD_REQ);
    assign fuse_idx_o   = idx_q;
    assign load_o       = cot_trim_wr_t'{we:   (state_q == COT_LD_WAIT) && fuse_ack_i,
                                         idx:  idx_q,
                                         data: fuse_data_i};                  // see RULE11
    assign done_o       = (state_q == COT_LD_DONE);

    chk_fuse_req_wait: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // see RULE11
        fuse_rd_o |=> (state_q == COT_LD_WAIT) && !fuse_rd_o)
        else $error("fuse request not followed by wait");

endmodule : cot_fuse_loader

// >>> testbench.sv
`timescale 1ns/1ns
module testbench;
    import cot_pkg::*;

    logic          sys_clk_i;
    logic          nrst_i;
    cot_reg_req_t  reg_req_i;
    cot_cal_cfg_t  cal_cfg_i;
    cot_trim_wr_t  cal_wr_i;
    logic          input_pair_b_i;
    logic          input_pair_c_i;
    logic          fault_clr_i;
    logic          fuse_ack_i;
    logic [11:0]   fuse_data_i;
    logic [15:0]   rd_data_o;
    logic          rd_valid_o;
    logic [11:0]   core0_offset_o;
    logic [11:0]   core1_offset_o;
    logic [11:0]   core2_offset_o;
    logic [11:0]   core3_offset_o;
    logic          spare_offset_cal_o;
    logic          host_blocked_o;
    logic          access_fault_o;
    logic          fuse_rd_o;
    logic [2:0]    fuse_idx_o;
    logic          load_done_o;
    int            errors;
    int            n_compared;
    logic [11:0]   addr_tab [5] = '{COT_CORE0_OFFSET_TRIM, COT_CORE1_OFFSET_TRIM,
        COT_CORE2_INPUT_A_OFFSET_TRIM, COT_CORE2_INPUT_B_OFFSET_TRIM, COT_CORE3_INPUT_C_OFFSET_TRIM};
    logic [11:0]   fuse_tab [5] = '{12'h101, 12'h212, 12'h323, 12'h434, 12'h545};

    cot_offset_trim_regs u_dut (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_req_i(reg_req_i), .cal_cfg_i(cal_cfg_i),
        .cal_wr_i(cal_wr_i), .input_pair_b_i(input_pair_b_i), .input_pair_c_i(input_pair_c_i),
        .fault_clr_i(fault_clr_i), .fuse_ack_i(fuse_ack_i), .fuse_data_i(fuse_data_i),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .core0_offset_o(core0_offset_o),
        .core1_offset_o(core1_offset_o), .core2_offset_o(core2_offset_o),
        .core3_offset_o(core3_offset_o), .spare_offset_cal_o(spare_offset_cal_o),
        .host_blocked_o(host_blocked_o), .access_fault_o(access_fault_o),
        .fuse_rd_o(fuse_rd_o), .fuse_idx_o(fuse_idx_o), .load_done_o(load_done_o));

    always #20 sys_clk_i = ~sys_clk_i;

    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : tick

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic finish_test;
        if (errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        reg_req_i = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        tick();
        reg_req_i.wr = 1'b0;
        tick();
    endtask : wr

    // Read data stands for one cycle only, so it is judged right after the taking edge.
    // An idle edge follows each access so the next strobe never merges with this one.
    task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
        reg_req_i = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
        tick();
        reg_req_i.rd = 1'b0;
        chk("rd_valid", {15'h0000, rd_valid_o}, 16'h0001);
        chk("rd_data", rd_data_o, exp);
        tick();
    endtask : rd_chk

    task automatic t_reset_fuse;
        int n;
        chk("reset trim", {4'h0, core0_offset_o}, 16'h0000);
        chk("reset blocked", {15'h0000, host_blocked_o}, 16'h0001);
        nrst_i = 1'b1;
        for (int i = 0; i < 5; i++) begin
            n = 0;
            while (fuse_rd_o !== 1'b1 && n < 20) begin
                tick();
                n++;
            end
            chk("fuse rd", {15'h0000, fuse_rd_o}, 16'h0001);
            chk("fuse idx", {13'h0000, fuse_idx_o}, 16'(i));
            fuse_ack_i = 1'b1;
            fuse_data_i = fuse_tab[i];
            tick();
            fuse_ack_i = 1'b0;
        end
        n = 0;
        while (load_done_o !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        chk("load done", {15'h0000, load_done_o}, 16'h0001);
        tick(3);
        chk("open after load", {15'h0000, host_blocked_o}, 16'h0000);
        chk("fuse core0", {4'h0, core0_offset_o}, {4'h0, fuse_tab[0]});
        chk("fuse core1", {4'h0, core1_offset_o}, {4'h0, fuse_tab[1]});
        for (int i = 0; i < 5; i++) rd_chk(addr_tab[i], {4'h0, fuse_tab[i]});
    endtask : t_reset_fuse

    task automatic t_map;
        for (int i = 0; i < 5; i++) wr(addr_tab[i], {4'h0, 12'h0a0 + 12'(i)});
        wr(12'h33a, 16'h0fff);
        tick(2);
        chk("core0", {4'h0, core0_offset_o}, 16'h00a0);
        chk("core1", {4'h0, core1_offset_o}, 16'h00a1);
        chk("core2 pair a", {4'h0, core2_offset_o}, 16'h00a2);
        chk("core3 idle", {4'h0, core3_offset_o}, 16'h0000);
        input_pair_b_i = 1'b1;
        input_pair_c_i = 1'b1;
        tick(2);
        chk("core2 pair b", {4'h0, core2_offset_o}, 16'h00a3);
        chk("core3 pair c", {4'h0, core3_offset_o}, 16'h00a4);
        for (int i = 0; i < 5; i++) rd_chk(addr_tab[i], {4'h0, 12'h0a0 + 12'(i)});
        rd_chk(12'h33a, 16'h0000);
        chk("no fault", {15'h0000, access_fault_o}, 16'h0000);
        cal_wr_i = '{we: 1'b1, idx: COT_IDX_CORE1, data: 12'h5a5};
        tick();
        cal_wr_i.we = 1'b0;
        tick(2);
        chk("cal write", {4'h0, core1_offset_o}, 16'h05a5);
    endtask : t_map

    // Each entry: {offset, background, continuous, done, running} and whether access is refused.
    task automatic t_gate;
        logic [4:0]  cfg [8] = '{5'b00001, 5'b10000, 5'b10010, 5'b01100,
                                 5'b11110, 5'b01000, 5'b00000, 5'b11001};
        logic        blk [8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
        logic [11:0] held;
        held = 12'h5a5;
        for (int i = 0; i < 8; i++) begin
            cal_cfg_i = cot_cal_cfg_t'(cfg[i]);
            tick(2);
            chk("blocked", {15'h0000, host_blocked_o}, {15'h0000, blk[i]});
            chk("spare cal", {15'h0000, spare_offset_cal_o},
                {15'h0000, cfg[i][4] & cfg[i][3] & ~cfg[i][2] & cfg[i][0]});
            wr(COT_CORE1_OFFSET_TRIM, {4'h0, 12'h200 + 12'(i)});
            if (!blk[i]) held = 12'h200 + 12'(i);
            rd_chk(COT_CORE1_OFFSET_TRIM, blk[i] ? 16'h0000 : {4'h0, held});
            tick();
            chk("fault", {15'h0000, access_fault_o}, {15'h0000, blk[i]});
            fault_clr_i = 1'b1;
            tick();
            fault_clr_i = 1'b0;
            tick();
            chk("fault clr", {15'h0000, access_fault_o}, 16'h0000);
        end
        cal_cfg_i = cot_cal_cfg_t'(5'b00000);
        tick(2);
        rd_chk(COT_CORE1_OFFSET_TRIM, {4'h0, held});
    endtask : t_gate

    initial begin
        sys_clk_i = 1'b0;
        nrst_i = 1'b0;
        reg_req_i = '0;
        cal_cfg_i = '0;
        cal_wr_i = '0;
        input_pair_b_i = 1'b0;
        input_pair_c_i = 1'b0;
        fault_clr_i = 1'b0;
        fuse_ack_i = 1'b0;
        fuse_data_i = 12'h000;
        errors = 0;
        n_compared = 0;
        tick(3);
        t_reset_fuse();
        t_map();
        t_gate();
        finish_test();
    end

    // The whole sequence needs about 135 cycles; this leaves ample margin.
    initial begin
        #200000;
        errors++;
        finish_test();
    end
endmodule : testbench
